// >>> meli_pkg.sv
// package: constants, field layout and carriers for the module event latch
package meli_pkg;

	localparam int unsigned MELI_W        = 32;
	localparam int unsigned MELI_BIT_TEMP = 14;
	localparam int unsigned MELI_BIT_SUPP = 13;
	localparam int unsigned MELI_BIT_SAFE = 10;
	localparam int unsigned MELI_BIT_INP  = 6;
	localparam int unsigned MELI_BIT_SERV = 4;

	// implemented event positions; everything else is reserved
	localparam logic [31:0] MELI_IMPL_MASK  = 32'h0000_6450;
	// positions that take part in blocking
	localparam logic [31:0] MELI_BLOCK_MASK = 32'h0000_6410;
	localparam logic [31:0] MELI_EVT_RESET  = 32'h0000_0000;
	localparam logic [31:0] MELI_ENA_RESET  = 32'h0000_0000;

	// raw module status conditions, active high
	typedef struct packed {
		logic temp_bad;
		logic supply_bad;
		logic safety_open;
		logic hw_fail;
	} meli_cond_t;

	// host command strobes, each a one-cycle pulse
	typedef struct packed {
		logic        flags_wr;
		logic [31:0] flags_wdata;
		logic        enable_wr;
		logic [31:0] enable_wdata;
		logic        bulk_clear;
		logic        clear_status;
	} meli_cmd_t;

endpackage

// >>> meli_sticky_bit.sv
// one sticky event bit with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module meli_sticky_bit (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// controls
	input  wire logic set_i,
	input  wire logic clr_i,
	// state
	output logic      q_o
);
	logic q_d;

	// set wins over a simultaneous clear; reset is the only other clear path
	assign q_d = set_i | (q_o & ~clr_i);

	// state flop
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			q_o <= 1'b0;
		end else begin
			q_o <= q_d;
		end
	end
endmodule
`default_nettype wire

// >>> meli_top.sv
// module event latch, enable mask, sum flag and high-voltage interlock
`timescale 1ns/1ps
`default_nettype none
module meli_top
	import meli_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// status conditions
	input  wire meli_cond_t  cond_i,
	input  wire logic        no_sum_error_i,
	input  wire logic        hv_on_i,
	// set value result reports, one-cycle pulses
	input  wire logic        set_reject_i,
	input  wire logic        set_ok_i,
	// host command strobes
	input  wire meli_cmd_t   cmd_i,
	// high-voltage requests to be gated
	input  wire logic        raise_req_i,
	input  wire logic        switch_on_req_i,
	// register read values
	output logic [31:0]      event_flags_o,
	output logic [31:0]      event_enable_o,
	// status outputs
	output logic             input_error_o,
	output logic             module_good_o,
	output logic             sum_event_o,
	output logic             blocked_o,
	// gated requests, channel clear and hv kill
	output logic             raise_grant_o,
	output logic             switch_on_grant_o,
	output logic             channel_events_clear_o,
	output logic             hv_kill_o
);

	////////////////////////////////////////////////////////////////////
	// state
	logic [31:0] enable_q;
	logic [31:0] enable_d;
	logic        inp_err_q;
	logic        inp_err_d;
	logic        svc_kill_q;
	logic        lock_q;
	logic        lock_d;
	logic [31:0] flags;

	////////////////////////////////////////////////////////////////////
	// set and clear vectors for the sticky bits
	wire logic [31:0] set_vec;
	wire logic [31:0] clr_vec;
	wire logic        clr_all;

	assign clr_all = cmd_i.clear_status;

	// condition mapping to event positions
	assign set_vec = ({31'h0000_0000, cond_i.temp_bad}    << MELI_BIT_TEMP)
	               | ({31'h0000_0000, cond_i.supply_bad}  << MELI_BIT_SUPP)
	               | ({31'h0000_0000, cond_i.safety_open} << MELI_BIT_SAFE)
	               | ({31'h0000_0000, inp_err_q}          << MELI_BIT_INP)
	               | ({31'h0000_0000, cond_i.hw_fail}     << MELI_BIT_SERV);

	// write-one clear of selected bits, or clear of all on clear-status
	assign clr_vec = ((cmd_i.flags_wr ? cmd_i.flags_wdata : 32'h0000_0000)
	                 | {MELI_W{clr_all}}) & MELI_IMPL_MASK;

	////////////////////////////////////////////////////////////////////
	// sticky event bits, only at implemented positions
	genvar gi;
	generate
		for (gi = 0; gi < MELI_W; gi++) begin : g_evt
			if (MELI_IMPL_MASK[gi]) begin : g_impl
				meli_sticky_bit u_bit (
					.clk_i     (clk_i),
					.reset_n_i (reset_n_i),
					.set_i     (set_vec[gi]),
					.clr_i     (clr_vec[gi]),
					.q_o       (flags[gi])
				);
			end else begin : g_rsvd
				assign flags[gi] = 1'b0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// enable mask register, reserved bits held at zero
	assign enable_d = cmd_i.enable_wr ? (cmd_i.enable_wdata & MELI_IMPL_MASK)
	                                  : enable_q;

	// input error status: set on reject, cleared by next good set
	assign inp_err_d = set_reject_i ? 1'b1 : (set_ok_i ? 1'b0 : inp_err_q);

	////////////////////////////////////////////////////////////////////
	// derived status
	wire logic [31:0] masked_evt;
	wire logic        block_now;
	wire logic        good_now;

	assign masked_evt = flags & enable_q;
	assign block_now  = |(masked_evt & MELI_BLOCK_MASK);
	assign good_now   = no_sum_error_i & ~flags[MELI_BIT_TEMP]
	                  & ~flags[MELI_BIT_SUPP] & ~flags[MELI_BIT_SAFE];

	// switch-on lock arms once hv is off while blocked, drops when unblocked
	assign lock_d = block_now & (lock_q | ~hv_on_i);

	////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			enable_q   <= MELI_ENA_RESET;
			inp_err_q  <= 1'b0;
			lock_q     <= 1'b0;
			svc_kill_q <= 1'b0;
		end else begin
			enable_q   <= enable_d;
			inp_err_q  <= inp_err_d;
			lock_q     <= lock_d;
			svc_kill_q <= svc_kill_q | cond_i.hw_fail;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			event_flags_o          <= MELI_EVT_RESET;
			event_enable_o         <= MELI_ENA_RESET;
			input_error_o          <= 1'b0;
			module_good_o          <= 1'b0;
			sum_event_o            <= 1'b0;
			blocked_o              <= 1'b0;
			raise_grant_o          <= 1'b0;
			switch_on_grant_o      <= 1'b0;
			channel_events_clear_o <= 1'b0;
			hv_kill_o              <= 1'b0;
		end else begin
			event_flags_o          <= flags;
			event_enable_o         <= enable_q;
			input_error_o          <= inp_err_q;
			module_good_o          <= good_now;
			sum_event_o            <= |masked_evt;
			blocked_o              <= block_now;
			raise_grant_o          <= raise_req_i & ~(hv_on_i & block_now)
			                        & ~svc_kill_q;
			switch_on_grant_o      <= switch_on_req_i & ~lock_d
			                        & ~svc_kill_q;
			channel_events_clear_o <= cmd_i.bulk_clear | clr_all;
			hv_kill_o              <= svc_kill_q | cond_i.hw_fail;
		end
	end

endmodule
`default_nettype wire

// >>> meli_chk.sv
// checker: latch, mask and interlock properties of the event block
`timescale 1ns/1ps
`default_nettype none
module meli_chk
	import meli_pkg::*;
(
	// clock and reset
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	// watched inputs and outputs
	input wire meli_cond_t  cond_i,
	input wire logic        hv_on_i,
	input wire meli_cmd_t   cmd_i,
	input wire logic        raise_req_i,
	input wire logic [31:0] event_flags_o,
	input wire logic [31:0] event_enable_o,
	input wire logic        sum_event_o,
	input wire logic        blocked_o,
	input wire logic        raise_grant_o,
	input wire logic        channel_events_clear_o,
	input wire logic        hv_kill_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// clear requests on bit 14 and the masked events
	wire logic        clr14 = cmd_i.flags_wr & cmd_i.flags_wdata[MELI_BIT_TEMP] | cmd_i.clear_status;
	wire logic [31:0] hit   = event_flags_o & event_enable_o;
	////////////////////////////////////////////////////////////////
	a_temp_latch: assert property (cond_i.temp_bad |-> ##2 event_flags_o[14])
		else $error("temp flag missing");
	a_flag_sticky: assert property ($fell(event_flags_o[14]) |-> $past(clr14, 2))
		else $error("flag dropped without clear");
	a_resv_zero: assert property (((event_flags_o | event_enable_o) & ~MELI_IMPL_MASK) == '0)
		else $error("reserved bit set");
	a_sum_flag: assert property (sum_event_o == |hit) else $error("sum flag wrong");
	a_block_lvl: assert property (blocked_o == |(hit & MELI_BLOCK_MASK))
		else $error("blocked level wrong");
	a_raise_gate: assert property ($past(reset_n_i) |-> raise_grant_o ==
		($past(raise_req_i) && !(blocked_o && $past(hv_on_i)) && !$past(hv_kill_o)))
		else $error("raise grant wrong");
	a_chan_clear: assert property (cmd_i.bulk_clear |=> channel_events_clear_o)
		else $error("no channel clear");
	a_kill_hold: assert property (hv_kill_o |=> hv_kill_o) else $error("kill dropped");
endmodule
bind meli_top meli_chk chk_u (.clk_i, .reset_n_i, .cond_i, .hv_on_i, .cmd_i, .raise_req_i,
	.event_flags_o, .event_enable_o, .sum_event_o, .blocked_o, .raise_grant_o,
	.channel_events_clear_o, .hv_kill_o);
`default_nettype wire

// >>> meli_host.sv
// host model: issues register and clear commands as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module meli_host
	import meli_pkg::*;
(
	// clock
	input  wire logic      clk_i,
	// command strobes
	output var  meli_cmd_t cmd_o
);
	initial cmd_o = '0;
	// one command launched and withdrawn on falling edges
	task automatic issue(input meli_cmd_t c);
		@(negedge clk_i) cmd_o = c;
		@(negedge clk_i) cmd_o = '0;
	endtask
endmodule
`default_nettype wire

// >>> module_event_latch_and_interlock_bench.sv
// bench: scenario tasks for the module event latch and interlock
`timescale 1ns/1ps
`default_nettype none
module module_event_latch_and_interlock_bench;
	import meli_pkg::*;
	logic        clk_i = 1'h0, reset_n_i = 1'h0;
	logic        hv_on = 1'h0, rej = 1'h0, ok = 1'h0, rreq = 1'h0, sreq = 1'h0;
	logic [31:0] flags, ena;
	logic        inp, good, sum, blk, rg, sg, chclr, kill;
	meli_cond_t  cond = '0;
	meli_cmd_t   cmd;
	int          error_cnt = 0, compares = 0;
	int          pos [4] = '{MELI_BIT_TEMP, MELI_BIT_SUPP, MELI_BIT_SAFE, MELI_BIT_SERV};
	////////////////////////////////////////////////////////////////
	// clock, host and device
	always #50 clk_i = ~clk_i;
	meli_host host_u (.clk_i, .cmd_o(cmd));
	meli_top dut_u (.clk_i, .reset_n_i, .cond_i(cond), .no_sum_error_i(1'h1), .hv_on_i(hv_on),
		.set_reject_i(rej), .set_ok_i(ok), .cmd_i(cmd), .raise_req_i(rreq),
		.switch_on_req_i(sreq), .event_flags_o(flags), .event_enable_o(ena),
		.input_error_o(inp), .module_good_o(good), .sum_event_o(sum), .blocked_o(blk),
		.raise_grant_o(rg), .switch_on_grant_o(sg), .channel_events_clear_o(chclr),
		.hv_kill_o(kill));
	////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic check(input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic wr(input meli_cmd_t c);
		host_u.issue(c);
		cyc(1);
	endtask
	task automatic do_reset;
		reset_n_i = 1'h0;
		cyc(12);
		reset_n_i = 1'h1;
		cyc(1);
	endtask
	////////////////////////////////////////////////////////////////
	// each condition latched for good, then write-one-to-clear
	task automatic t_latch;
		logic [31:0] exp;
		exp = '0;
		for (int i = 0; i < 4; i++) begin
			cond = 4'h8 >> i;
			cyc(1);
			cond = '0;
			cyc(2);
			exp[pos[i]] = 1'h1;
			check(flags, exp);
		end
		check(kill, 32'h1);
		wr('{flags_wr: 1'h1, flags_wdata: 32'hFFFF_BFFF, default: '0});
		check(flags, 32'h4000);
		$display("latch test done");
	endtask
	// mask keeps implemented bits; masked temp blocks raise and switch-on
	task automatic t_block;
		cond = 4'h8;
		wr('{enable_wr: 1'h1, enable_wdata: 32'hFFFF_FFFF, default: '0});
		cond = '0;
		check(ena, MELI_IMPL_MASK);
		check(sum, 32'h1);
		hv_on = 1'h1;
		rreq = 1'h1;
		cyc(2);
		check(rg, 32'h0);
		hv_on = 1'h0;
		sreq = 1'h1;
		cyc(2);
		check(sg, 32'h0);
		wr('{enable_wr: 1'h1, enable_wdata: 32'h0000_2450, default: '0});
		cyc(2);
		check({sum, blk, sg, rg}, 32'h3);
		$display("block test done");
	endtask
	// rejected value sets input error; success drops status, event stays
	task automatic t_input;
		rej = 1'h1;
		cyc(1);
		rej = 1'h0;
		cyc(2);
		check({inp, good}, 32'h2);
		ok = 1'h1;
		cyc(1);
		ok = 1'h0;
		cyc(2);
		check({inp, blk, sum}, 32'h1);
		check(flags, 32'h4040);
		$display("input test done");
	endtask
	// bulk clear leaves module flags; clear-status clears them
	task automatic t_clear;
		host_u.issue('{bulk_clear: 1'h1, default: '0});
		check(chclr, 32'h1);
		check(flags, 32'h4040);
		wr('{clear_status: 1'h1, default: '0});
		cyc(1);
		check({flags[14], good}, 32'h1);
		$display("clear test done");
	endtask
	////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic results;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		do_reset;
		t_latch;
		do_reset;
		t_block;
		t_input;
		t_clear;
		results;
	end
endmodule
`default_nettype wire
